// >>> logic/oprf_consts.svh
`ifndef OPRF_CONSTS_SVH
`define OPRF_CONSTS_SVH

// ----------------------------------------
// Frame identifiers
// ----------------------------------------
`define OPRF_PID_REQUEST 8'h3C
`define OPRF_PID_RESPONSE 8'h7D

// ----------------------------------------
// Request fields
// ----------------------------------------
`define OPRF_APP_CMD 8'h80
`define OPRF_CMD_FLAG_BIT 7
`define OPRF_CMD_PART1 7'h04
`define OPRF_CMD_PART2 7'h05
`define OPRF_ADDR_PREFIX 2'h3
`define OPRF_PAD_BYTE 8'hFF

// ----------------------------------------
// Byte positions and counts
// ----------------------------------------
`define OPRF_IDX_APP 4'h1
`define OPRF_IDX_CMD 4'h2
`define OPRF_IDX_ADDR 4'h3
`define OPRF_DATA_BYTES 4'h8
`define OPRF_CSUM_IDX 4'h9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OPRF_BYTE_RST 8'h00
`define OPRF_IDX_RST 4'h0

`endif

// >>> logic/oprf_pkg.sv
package oprf_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OPRF_IDLE = 4'b0001,
    OPRF_RX = 4'b0010,
    OPRF_WAIT = 4'b0100,
    OPRF_TX = 4'b1000
  } oprf_state_e;

  typedef logic [7:0] oprf_byte_t;
  typedef logic [3:0] oprf_idx_t;
  typedef logic [63:0] oprf_frame_t;

endpackage : oprf_pkg

// >>> logic/oprf_sum_if.sv
`timescale 1ns/1ns
interface oprf_sum_if;
  import oprf_pkg::*;
  logic clear;
  logic add;
  oprf_byte_t dataIn;
  oprf_byte_t sumInv;
  modport user (output clear, output add, output dataIn, input sumInv);
  modport engine (input clear, input add, input dataIn, output sumInv);
endinterface : oprf_sum_if

// >>> logic/oprf_checksum.sv
`timescale 1ns/1ns
module oprf_checksum (
  input wire logic clk,
  input wire logic reset_n,
  oprf_sum_if.engine sumPort
);
  import oprf_pkg::*;

  // ----------------------------------------
  // Classic sum with end-around carry
  // ----------------------------------------
  oprf_byte_t acc_r;
  oprf_byte_t acc_nxt;
  logic [8:0] rawSum;

  assign rawSum = {1'b0, acc_r} + {1'b0, sumPort.dataIn};
  // A header that also opens a response seeds the sum with the first byte
  assign acc_nxt = sumPort.clear ? (sumPort.add ? sumPort.dataIn : 8'h00) :
                   sumPort.add ? oprf_byte_t'(rawSum[7:0] + {7'h00, rawSum[8]}) : acc_r;
  assign sumPort.sumInv = ~acc_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
    end
  end

endmodule : oprf_checksum

// >>> logic/oprf_readout.sv
`timescale 1ns/1ns
`include "oprf_consts.svh"
module oprf_readout (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pidValid,
  input wire oprf_pkg::oprf_byte_t pid,
  input wire logic rxByteValid,
  input wire oprf_pkg::oprf_byte_t rxByte,
  input wire logic frameAbort,
  input wire logic txTake,
  output logic txActive,
  output oprf_pkg::oprf_byte_t txByte,
  output logic txDone,
  output logic reqError,
  input wire logic cmdValid,
  input wire logic cmdIsColorShort,
  input wire logic cmdIsIntensity,
  output logic cmdExecute,
  input wire logic [5:0] nodeAddr,
  input wire logic lowBaud,
  input wire logic diagAllOff,
  input wire logic defaultBit,
  input wire logic errOff,
  input wire logic twProg,
  input wire logic lockBit1,
  input wire logic commandLockoutBit,
  input wire logic lockBit2,
  input wire logic ledModFreq,
  input wire logic thCont,
  input wire logic [3:0] groupId,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow1Col1,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow1Col2,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow1Col3,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow2Col1,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow2Col2,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow2Col3,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow3Col1,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow3Col2,
  input wire oprf_pkg::oprf_byte_t calibCoeffRow3Col3
);
  import oprf_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic oprf_byte_t byteOf(input oprf_frame_t frame, input oprf_idx_t idx);
    oprf_byte_t sel;
    sel = 8'h00;
    case (idx)
      4'h1: sel = frame[7:0];
      4'h2: sel = frame[15:8];
      4'h3: sel = frame[23:16];
      4'h4: sel = frame[31:24];
      4'h5: sel = frame[39:32];
      4'h6: sel = frame[47:40];
      4'h7: sel = frame[55:48];
      4'h8: sel = frame[63:56];
      default: sel = 8'h00;
    endcase
    return sel;
  endfunction : byteOf

  // ----------------------------------------
  // State
  // ----------------------------------------
  oprf_state_e state_r;
  oprf_state_e state_nxt;
  oprf_idx_t idx_r;
  oprf_idx_t idx_nxt;
  logic part2_r;
  logic part2_nxt;
  logic cmdOk_r;
  logic cmdOk_nxt;
  logic cmdPart2_r;
  logic cmdPart2_nxt;
  oprf_byte_t txByte_r;
  oprf_byte_t txByte_nxt;
  logic txDone_r;
  logic txDone_nxt;
  logic reqError_r;
  logic reqError_nxt;

  oprf_sum_if sumBus ();

  oprf_checksum uChecksum (
    .clk(clk),
    .reset_n(reset_n),
    .sumPort(sumBus)
  );

  // ----------------------------------------
  // Response images
  // ----------------------------------------
  wire oprf_byte_t addrByte = {`OPRF_ADDR_PREFIX, nodeAddr};
  wire oprf_frame_t part1Data = {
    calibCoeffRow1Col3,
    calibCoeffRow1Col2,
    calibCoeffRow1Col1,
    {lockBit1, commandLockoutBit, nodeAddr},
    {defaultBit, errOff, twProg, 5'h1F},
    8'hFF,
    {6'h3F, lowBaud, diagAllOff},
    addrByte
  };
  wire oprf_frame_t part2Data = {
    {lockBit2, ledModFreq, 1'b1, thCont, groupId},
    calibCoeffRow3Col3,
    calibCoeffRow3Col2,
    calibCoeffRow3Col1,
    calibCoeffRow2Col3,
    calibCoeffRow2Col2,
    calibCoeffRow2Col1,
    addrByte
  };
  wire oprf_frame_t respData = part2_r ? part2Data : part1Data;

  // ----------------------------------------
  // Request decoding
  // ----------------------------------------
  wire logic lockout = commandLockoutBit;
  wire logic pidReq = pidValid && (pid == `OPRF_PID_REQUEST) && !lockout;
  wire logic pidResp = pidValid && (pid == `OPRF_PID_RESPONSE);
  wire logic rxData = (state_r == OPRF_RX) && rxByteValid && (idx_r < `OPRF_CSUM_IDX);
  wire logic rxCsum = (state_r == OPRF_RX) && rxByteValid && (idx_r == `OPRF_CSUM_IDX);
  wire logic csumGood = (rxByte == sumBus.sumInv);
  wire logic isApp = (idx_r == `OPRF_IDX_APP) && (rxByte == `OPRF_APP_CMD);
  wire logic isCmd1 = (rxByte == {1'b1, `OPRF_CMD_PART1});
  wire logic isCmd2 = (rxByte == {1'b1, `OPRF_CMD_PART2});
  wire logic isAddr = (rxByte == addrByte);
  wire logic isPad = (rxByte == `OPRF_PAD_BYTE);
  wire logic fieldOk = (idx_r == `OPRF_IDX_APP) ? isApp :
                       (idx_r == `OPRF_IDX_CMD) ? (isCmd1 || isCmd2) :
                       (idx_r == `OPRF_IDX_ADDR) ? isAddr : isPad;
  wire logic txLoad = (state_r == OPRF_TX) && txTake && (idx_r < `OPRF_DATA_BYTES);
  wire logic txCsum = (state_r == OPRF_TX) && txTake && (idx_r == `OPRF_DATA_BYTES);
  wire logic txEnd = (state_r == OPRF_TX) && txTake && (idx_r == `OPRF_CSUM_IDX);
  wire logic respStart = (state_r == OPRF_WAIT) && pidResp && !frameAbort;
  wire oprf_idx_t idxInc = oprf_idx_t'(idx_r + 4'h1);

  // ----------------------------------------
  // Checksum feed
  // ----------------------------------------
  assign sumBus.clear = pidValid;
  assign sumBus.add = rxData || respStart || txLoad;
  assign sumBus.dataIn = (state_r == OPRF_RX) ? rxByte : txByte_nxt;

  // ----------------------------------------
  // Other commands under lockout
  // ----------------------------------------
  assign cmdExecute = cmdValid && (!lockout || cmdIsColorShort || cmdIsIntensity);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    part2_nxt = part2_r;
    cmdOk_nxt = cmdOk_r;
    cmdPart2_nxt = cmdPart2_r;
    txByte_nxt = txByte_r;
    txDone_nxt = 1'b0;
    reqError_nxt = 1'b0;
    case (state_r)
      OPRF_IDLE: begin
        if (pidReq && !frameAbort) begin
          state_nxt = OPRF_RX;
          idx_nxt = 4'h1;
          cmdOk_nxt = 1'b1;
          cmdPart2_nxt = 1'b0;
        end
      end
      OPRF_RX: begin
        if (frameAbort) begin
          state_nxt = OPRF_IDLE;
        end else if (rxData) begin
          idx_nxt = idxInc;
          cmdOk_nxt = cmdOk_r && fieldOk;
          if (idx_r == `OPRF_IDX_CMD) begin
            cmdPart2_nxt = isCmd2;
          end
        end else if (rxCsum) begin
          if (!csumGood) begin
            reqError_nxt = 1'b1;
            state_nxt = OPRF_IDLE;
          end else if (cmdOk_r) begin
            state_nxt = OPRF_WAIT;
            part2_nxt = cmdPart2_r;
          end else begin
            state_nxt = OPRF_IDLE;
          end
        end
      end
      OPRF_WAIT: begin
        if (frameAbort) begin
          state_nxt = OPRF_IDLE;
        end else if (respStart) begin
          state_nxt = OPRF_TX;
          idx_nxt = 4'h1;
          txByte_nxt = byteOf(respData, 4'h1);
        end else if (pidValid) begin
          state_nxt = OPRF_IDLE;
        end
      end
      OPRF_TX: begin
        if (frameAbort) begin
          state_nxt = OPRF_IDLE;
        end else if (txLoad) begin
          idx_nxt = idxInc;
          txByte_nxt = byteOf(respData, idxInc);
        end else if (txCsum) begin
          idx_nxt = idxInc;
          txByte_nxt = sumBus.sumInv;
        end else if (txEnd) begin
          state_nxt = OPRF_IDLE;
          txDone_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = OPRF_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= OPRF_IDLE;
      idx_r <= `OPRF_IDX_RST;
      part2_r <= 1'b0;
      cmdOk_r <= 1'b0;
      cmdPart2_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      part2_r <= part2_nxt;
      cmdOk_r <= cmdOk_nxt;
      cmdPart2_r <= cmdPart2_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txByte_r <= `OPRF_BYTE_RST;
      txDone_r <= 1'b0;
      reqError_r <= 1'b0;
    end else begin
      txByte_r <= txByte_nxt;
      txDone_r <= txDone_nxt;
      reqError_r <= reqError_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign txActive = (state_r == OPRF_TX);
  assign txByte = txByte_r;
  assign txDone = txDone_r;
  assign reqError = reqError_r;

endmodule : oprf_readout

// >>> testbench/oprf_readout_asserts.sv
`timescale 1ns/1ns
module oprf_readout_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pidValid,
  input wire oprf_pkg::oprf_byte_t pid,
  input wire logic rxByteValid,
  input wire logic txTake,
  input wire logic txActive,
  input wire oprf_pkg::oprf_byte_t txByte,
  input wire logic txDone,
  input wire logic reqError,
  input wire logic cmdValid,
  input wire logic cmdIsColorShort,
  input wire logic cmdIsIntensity,
  input wire logic cmdExecute,
  input wire logic commandLockoutBit,
  input wire logic [5:0] nodeAddr
);
  import oprf_pkg::*;
  // ----------------------------------------
  // Taken byte counter
  // ----------------------------------------
  logic [3:0] takeCnt_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) takeCnt_r <= 4'h0;
    else takeCnt_r <= txActive ? takeCnt_r + {3'h0, txTake} : 4'h0;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence lastTake;
    txActive && txTake && takeCnt_r == 4'h8;
  endsequence
  sequence holdStep;
    txActive && !txTake ##1 txActive;
  endsequence
  cmd_gate_a: assert property (cmdExecute == (cmdValid &&
    (!commandLockoutBit || cmdIsColorShort || cmdIsIntensity))) else $error("cmd gate");
  lock_silent_a: assert property (commandLockoutBit && !txActive |=> !txActive)
    else $error("reply under lockout");
  resp_start_a: assert property ($rose(txActive) |-> $past(pidValid) &&
    $past(pid) == 8'h7D) else $error("reply without header");
  first_byte_a: assert property ($rose(txActive) |-> txByte == {2'h3, nodeAddr})
    else $error("first byte");
  byte_hold_a: assert property (holdStep |-> $stable(txByte)) else $error("byte moved");
  resp_end_a: assert property (lastTake |=> txDone && !txActive) else $error("no end");
  done_count_a: assert property (txDone |-> takeCnt_r == 4'h9) else $error("count");
  done_pulse_a: assert property (txDone |=> !txDone) else $error("done width");
  err_cause_a: assert property (reqError |-> !txActive &&
    ($past(rxByteValid, 1) || $past(rxByteValid, 2))) else $error("stray error");
endmodule : oprf_readout_asserts

// >>> testbench/oprf_master_model.sv
`timescale 1ns/1ns
module oprf_master_model (
  input wire logic clk,
  input wire logic txActive,
  input wire oprf_pkg::oprf_byte_t txByte,
  output logic pidValid,
  output oprf_pkg::oprf_byte_t pid,
  output logic rxByteValid,
  output oprf_pkg::oprf_byte_t rxByte,
  output logic txTake
);
  import oprf_pkg::*;
  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  initial begin
    pidValid = 0;
    pid = 8'h00;
    rxByteValid = 0;
    rxByte = 8'h00;
    txTake = 0;
  end
  function automatic oprf_byte_t csum(input oprf_byte_t d [0:8]);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < 8; i++) begin
      s = {1'h0, s[7:0]} + {1'h0, d[i]};
      s = {1'h0, s[7:0]} + {8'h00, s[8]};
    end
    return ~s[7:0];
  endfunction : csum
  task automatic hdr(input oprf_byte_t id);
    @(negedge clk);
    pidValid = 1;
    pid = id;
    @(negedge clk);
    pidValid = 0;
    pid = ~id;
  endtask : hdr
  task automatic sendReq(input logic [6:0] code, input logic [5:0] ad,
    input oprf_byte_t pad, input oprf_byte_t sx);
    oprf_byte_t q [0:8];
    q[0] = 8'h80;
    q[1] = {1'h1, code};
    q[2] = {2'h3, ad};
    for (int i = 3; i < 8; i++) q[i] = pad;
    q[8] = csum(q) ^ sx;
    hdr(8'h3C);
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      rxByteValid = 1;
      rxByte = q[i];
    end
    @(negedge clk);
    rxByteValid = 0;
    rxByte = ~rxByte;
  endtask : sendReq
  task automatic readResp(input int gap, output oprf_byte_t r [0:8], output logic act);
    act = txActive;
    if (act) begin
      for (int i = 0; i < 9; i++) begin
        if (gap > 0) begin
          txTake = 0;
          repeat (gap) @(negedge clk);
        end
        r[i] = txByte;
        txTake = 1;
        @(negedge clk);
      end
      txTake = 0;
    end
  endtask : readResp
endmodule : oprf_master_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
  import oprf_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, reset_n, pidValid, rxByteValid, txTake, txActive, txDone, reqError, errSeen;
  logic frameAbort = 0, cmdValid = 0, cmdIsColorShort = 0, cmdIsIntensity = 0;
  logic commandLockoutBit = 0, lowBaud = 1, diagAllOff = 0, defaultBit = 1, errOff = 0;
  logic twProg = 1, lockBit1 = 0, lockBit2 = 1, ledModFreq = 0, thCont = 1, cmdExecute;
  logic [5:0] nodeAddr = 6'h2A;
  logic [3:0] groupId = 4'h6;
  oprf_byte_t pid, rxByte, txByte;
  oprf_byte_t cf [0:8] = '{8'h11, 8'h12, 8'h13, 8'h21, 8'h22, 8'h23, 8'h31, 8'h32, 8'h33};
  int n_mismatch, compares;
  oprf_master_model u_m (.clk, .txActive, .txByte, .pidValid, .pid, .rxByteValid, .rxByte,
    .txTake);
  oprf_readout u_dut (.clk, .reset_n, .pidValid, .pid, .rxByteValid, .rxByte, .frameAbort,
    .txTake, .txActive, .txByte, .txDone, .reqError, .cmdValid, .cmdIsColorShort,
    .cmdIsIntensity, .cmdExecute, .nodeAddr, .lowBaud, .diagAllOff, .defaultBit, .errOff,
    .twProg, .lockBit1, .commandLockoutBit, .lockBit2, .ledModFreq, .thCont, .groupId,
    .calibCoeffRow1Col1(cf[0]), .calibCoeffRow1Col2(cf[1]), .calibCoeffRow1Col3(cf[2]),
    .calibCoeffRow2Col1(cf[3]), .calibCoeffRow2Col2(cf[4]), .calibCoeffRow2Col3(cf[5]),
    .calibCoeffRow3Col1(cf[6]), .calibCoeffRow3Col2(cf[7]), .calibCoeffRow3Col3(cf[8]));
  always @(posedge clk) if (reqError === 1'h1) errSeen <= 1;
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_read(input logic part, input int gap);
    oprf_byte_t e [0:8];
    oprf_byte_t r [0:8];
    logic act;
    u_m.sendReq(part ? 7'h05 : 7'h04, nodeAddr, 8'hFF, 8'h00);
    u_m.hdr(8'h7D);
    u_m.readResp(gap, r, act);
    e[0] = {2'h3, nodeAddr};
    if (!part) begin
      e[1] = {6'h3F, lowBaud, diagAllOff};
      e[2] = 8'hFF;
      e[3] = {defaultBit, errOff, twProg, 5'h1F};
      e[4] = {lockBit1, commandLockoutBit, nodeAddr};
      for (int i = 5; i < 8; i++) e[i] = cf[i - 5];
    end else begin
      for (int i = 1; i < 7; i++) e[i] = cf[i + 2];
      e[7] = {lockBit2, ledModFreq, 1'h1, thCont, groupId};
    end
    e[8] = u_m.csum(e);
    `CHK(act, 1'h1)
    for (int i = 0; i < 9; i++) `CHK(r[i], e[i])
    `CHK(txDone, 1'h1)
  endtask : t_read
  task automatic t_none(input oprf_byte_t pad, input oprf_byte_t sx, input int kind);
    oprf_byte_t r [0:8];
    logic act;
    errSeen = 0;
    u_m.sendReq(7'h04, nodeAddr, pad, sx);
    if (kind == 1) u_m.hdr(8'h20);
    if (kind == 2) begin
      @(negedge clk);
      frameAbort = 1;
      @(negedge clk);
      frameAbort = 0;
    end
    repeat (2) @(negedge clk);
    `CHK(errSeen, sx != 8'h00)
    u_m.hdr(8'h7D);
    u_m.readResp(0, r, act);
    `CHK(act, 1'h0)
  endtask : t_none
  task automatic t_lock();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {commandLockoutBit, cmdIsColorShort, cmdIsIntensity} = i[2:0];
      cmdValid = 1;
      #1;
      `CHK(cmdExecute, i != 4)
    end
    @(negedge clk);
    cmdValid = 0;
    commandLockoutBit = 1;
    t_none(8'hFF, 8'h00, 0);
    commandLockoutBit = 0;
  endtask : t_lock
  task automatic conclude();
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    reset_n = 0;
    repeat (6) @(negedge clk);
    reset_n = 1;
    t_read(0, 0);
    t_read(1, 2);
    t_none(8'hFF, 8'h01, 0);
    t_none(8'hFE, 8'h00, 0);
    t_none(8'hFF, 8'h00, 1);
    t_none(8'hFF, 8'h00, 2);
    t_lock();
    t_read(0, 1);
    conclude();
  end
endmodule : tb_top
bind oprf_readout oprf_readout_asserts u_chk (.clk, .reset_n, .pidValid, .pid, .rxByteValid,
  .txTake, .txActive, .txByte, .txDone, .reqError, .cmdValid, .cmdIsColorShort,
  .cmdIsIntensity, .cmdExecute, .commandLockoutBit, .nodeAddr);
